// ### pkg/dao_params.svh
`ifndef DAO_PARAMS_SVH
`define DAO_PARAMS_SVH

// conversion clock rate
`define DAO_CLK_MHZ 25
// sample width and pipeline depth in sampling periods
`define DAO_SAMPLE_W 8
`define DAO_LATENCY 5
// wake-up times as printed, in ns
`define DAO_T_SHDN_NS 20000
`define DAO_T_STBY_NS 5500
`define DAO_T_IDLE_NS 5
// least times round up to whole cycles, never below one
`define DAO_NS2CYC(ns) ((((ns) * `DAO_CLK_MHZ) + 999) / 1000)
`define DAO_SHDN_CYC `DAO_NS2CYC(`DAO_T_SHDN_NS)
`define DAO_STBY_CYC `DAO_NS2CYC(`DAO_T_STBY_NS)
`define DAO_IDLE_CYC `DAO_NS2CYC(`DAO_T_IDLE_NS)
// reset values
`define DAO_RST_WORD 8'h00
`define DAO_RST_CNT 10'h000
// offset binary: top bit inverted from two's complement
`define DAO_MSB_FLIP 8'h80

`endif

// ### pkg/dao_pkg.sv
package dao_pkg;
	// power modes, code is {power_select_low, power_select_high}
	typedef enum logic [1:0] {
		DAO_M_SHDN = 2'b00,
		DAO_M_STBY = 2'b01,
		DAO_M_IDLE = 2'b10,
		DAO_M_NORM = 2'b11
	} dao_mode_t;
	// wake-up counter, wide enough for the longest wait
	typedef logic [9:0] dao_cnt_t;
	typedef logic [7:0] dao_word_t;
endpackage

// ### hw/dao_pipe.sv
`timescale 1ns/1ps
`include "dao_params.svh"

// sample-pair delay line, one stage per sampling period
module dao_pipe
	import dao_pkg::*;
#(
	parameter int DEPTH = `DAO_LATENCY
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// push side
	input wire logic i_push,
	input wire dao_word_t i_a,
	input wire dao_word_t i_b,
	// tail of the line, value before the current push
	output dao_word_t o_a,
	output dao_word_t o_b
);
	dao_word_t a_r [DEPTH];
	dao_word_t b_r [DEPTH];
	dao_word_t a_nxt [DEPTH];
	dao_word_t b_nxt [DEPTH];

	// shift only on a conversion; a halted core freezes the line
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			a_nxt[i] = a_r[i];
			b_nxt[i] = b_r[i];
		end
		if (i_push) begin
			a_nxt[0] = i_a;
			b_nxt[0] = i_b;
			for (int i = 1; i < DEPTH; i++) begin
				a_nxt[i] = a_r[i-1];
				b_nxt[i] = b_r[i-1];
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				a_r[i] <= `DAO_RST_WORD;
				b_r[i] <= `DAO_RST_WORD;
			end
		end else begin
			a_r <= a_nxt;
			b_r <= b_nxt;
		end
	end

	assign o_a = a_r[DEPTH-1];
	assign o_b = b_r[DEPTH-1];
endmodule // dao_pipe

// ### hw/dao_top.sv
`timescale 1ns/1ps
`include "dao_params.svh"

// Contract
// - samples leave as offset binary; bipolar zero is 8'h80, negative full scale 8'h00.
// - both selects low: core, reference, clock distribution off, outputs tri-stated.
// - low 0, high 1: reference and clock on, core off, outputs tri-stated.
// - low 1, high 0: everything powered but outputs forced to tri-state.
// - both selects high: everything powered and outputs driven.
// - leaving shutdown, wait 20 us for the reference before operating.
// - leaving standby, wait 5.5 us for the core before conversions resume.
// - leaving idle, output drivers turn on within 5 ns; the driver timer waits one whole 40 ns clock cycle instead.
// - when drivers turn on, the last converted word is shown first.
// - first channel updates on rising edge, second on falling; indicator high for first.
// - both sampled on rising edge; latency 5 periods first, 5.5 second.
module dao_top
	import dao_pkg::*;
#(
	parameter int SHDN_CYC = `DAO_SHDN_CYC,
	parameter int STBY_CYC = `DAO_STBY_CYC,
	parameter int IDLE_CYC = `DAO_IDLE_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// sampling clock and power select pins
	input wire logic i_smp_clk,
	input wire logic i_power_select_low,
	input wire logic i_power_select_high,
	// quantised words from the core, two's complement
	input wire dao_word_t i_first_channel,
	input wire dao_word_t i_second_channel,
	// multiplexed output bus
	output dao_word_t o_sample_bits,
	output logic o_sample_bits_oe,
	output logic o_chan_ind,
	output logic o_chan_ind_oe,
	// section power enables and status
	output logic o_core_pwr,
	output logic o_ref_pwr,
	output logic o_clk_dist_pwr,
	output logic o_conv_valid
);
	// saturating count toward a limit
	function automatic dao_cnt_t sat_inc(input dao_cnt_t c, input dao_cnt_t lim);
		sat_inc = (c >= lim) ? lim : dao_cnt_t'(c + 10'h001);
	endfunction

	// two's complement to offset binary
	function automatic dao_word_t to_offs(input dao_word_t w);
		to_offs = w ^ `DAO_MSB_FLIP;
	endfunction

	localparam dao_cnt_t SHDN_LIM = dao_cnt_t'(SHDN_CYC);
	localparam dao_cnt_t STBY_LIM = dao_cnt_t'(STBY_CYC);
	localparam dao_cnt_t IDLE_LIM = dao_cnt_t'(IDLE_CYC);

	// pin synchronisers: s1 feeds s2 only, level changes when s2 and s3 agree
	logic [2:0] s1_r, s2_r, s3_r, s1_nxt, s2_nxt, s3_nxt;
	logic [2:0] lvl_r, lvl_nxt;

	always_comb begin
		s1_nxt = {i_smp_clk, i_power_select_low, i_power_select_high};
		s2_nxt = s1_r;
		s3_nxt = s2_r;
		for (int i = 0; i < 3; i++) begin
			lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
			s3_r <= 3'h0;
			lvl_r <= 3'h0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			lvl_r <= lvl_nxt;
		end
	end

	dao_mode_t mode;
	logic smp_rise, smp_fall;
	assign mode = dao_mode_t'(lvl_r[1:0]);
	// sampling edges seen one cycle before the filtered level register moves
	assign smp_rise = lvl_nxt[2] & ~lvl_r[2];
	assign smp_fall = ~lvl_nxt[2] & lvl_r[2];

	// power decode per mode
	always_comb begin
		unique case (mode)
			DAO_M_SHDN: {o_core_pwr, o_ref_pwr, o_clk_dist_pwr} = 3'h0;
			DAO_M_STBY: {o_core_pwr, o_ref_pwr, o_clk_dist_pwr} = 3'h3;
			DAO_M_IDLE: {o_core_pwr, o_ref_pwr, o_clk_dist_pwr} = 3'h7;
			DAO_M_NORM: {o_core_pwr, o_ref_pwr, o_clk_dist_pwr} = 3'h7;
		endcase
	end

	// wake timers: reference charge, core start, driver start
	dao_cnt_t ref_cnt_r, core_cnt_r, drv_cnt_r;
	dao_cnt_t ref_cnt_nxt, core_cnt_nxt, drv_cnt_nxt;
	logic ref_ok, core_ok, drv_ok;

	always_comb begin
		ref_cnt_nxt = o_ref_pwr ? sat_inc(ref_cnt_r, SHDN_LIM) : `DAO_RST_CNT;
		core_cnt_nxt = o_core_pwr ? sat_inc(core_cnt_r, STBY_LIM) : `DAO_RST_CNT;
		drv_cnt_nxt = (mode == DAO_M_NORM) ? sat_inc(drv_cnt_r, IDLE_LIM) : `DAO_RST_CNT;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ref_cnt_r <= `DAO_RST_CNT;
			core_cnt_r <= `DAO_RST_CNT;
			drv_cnt_r <= `DAO_RST_CNT;
		end else begin
			ref_cnt_r <= ref_cnt_nxt;
			core_cnt_r <= core_cnt_nxt;
			drv_cnt_r <= drv_cnt_nxt;
		end
	end

	assign ref_ok = ref_cnt_r == SHDN_LIM;
	// core timing runs alongside the reference count, so shutdown exit costs the longer of the two
	assign core_ok = (core_cnt_r == STBY_LIM) & ref_ok;
	assign drv_ok = drv_cnt_r == IDLE_LIM;
	assign o_conv_valid = core_ok;
	// drivers on only in normal mode once everything is awake
	assign o_sample_bits_oe = (mode == DAO_M_NORM) & drv_ok & core_ok;
	assign o_chan_ind_oe = o_sample_bits_oe;

	// latency line, both channels pushed on the same rising edge
	logic push;
	dao_word_t push_a, push_b, tail_a, tail_b;
	assign push = smp_rise & core_ok;
	assign push_a = to_offs(i_first_channel);
	assign push_b = to_offs(i_second_channel);

	dao_pipe #(
		.DEPTH(`DAO_LATENCY)
	) u_pipe (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_push(push),
		.i_a(push_a),
		.i_b(push_b),
		.o_a(tail_a),
		.o_b(tail_b)
	);

	// output register: tracks every conversion even while tri-stated, so
	// re-enabling always shows the newest word; halted core freezes it
	dao_word_t word_r, word_nxt, bhold_r, bhold_nxt;
	logic ind_r, ind_nxt;

	always_comb begin
		word_nxt = word_r;
		bhold_nxt = bhold_r;
		ind_nxt = ind_r;
		if (push) begin
			word_nxt = tail_a;
			bhold_nxt = tail_b;
			ind_nxt = 1'b1;
		end else if (smp_fall & core_ok) begin
			word_nxt = bhold_r;
			ind_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			word_r <= `DAO_RST_WORD;
			bhold_r <= `DAO_RST_WORD;
			ind_r <= 1'b0;
		end else begin
			word_r <= word_nxt;
			bhold_r <= bhold_nxt;
			ind_r <= ind_nxt;
		end
	end

	// the held word drives the pins as soon as the enable rises
	assign o_sample_bits = word_r;
	assign o_chan_ind = ind_r;

	// checks; any update of the output register, either channel
	logic word_upd;
	assign word_upd = push | (smp_fall & core_ok);

	sequence s_first_upd;
		push;
	endsequence
	sequence s_second_upd;
		smp_fall && core_ok && !push;
	endsequence

	property p_shdn;
		@(posedge i_clk) disable iff (!i_arst_n)
		(mode == DAO_M_SHDN) |-> !o_core_pwr && !o_ref_pwr && !o_clk_dist_pwr && !o_sample_bits_oe;
	endproperty
	a_shdn: assert property (p_shdn) else $error("shutdown not fully off");

	property p_stby;
		@(posedge i_clk) disable iff (!i_arst_n)
		(mode == DAO_M_STBY) |-> !o_core_pwr && o_ref_pwr && o_clk_dist_pwr && !o_sample_bits_oe;
	endproperty
	a_stby: assert property (p_stby) else $error("standby power wrong");

	property p_idle;
		@(posedge i_clk) disable iff (!i_arst_n)
		(mode == DAO_M_IDLE) |-> o_core_pwr && o_ref_pwr && !o_sample_bits_oe && !o_chan_ind_oe;
	endproperty
	a_idle: assert property (p_idle) else $error("idle drives outputs");

	property p_norm;
		@(posedge i_clk) disable iff (!i_arst_n)
		(mode == DAO_M_NORM && core_ok) ##1 (mode == DAO_M_NORM && core_ok)
		|-> o_sample_bits_oe && o_chan_ind_oe;
	endproperty
	a_norm: assert property (p_norm) else $error("normal mode not driving");

	property p_ref_wake;
		@(posedge i_clk) disable iff (!i_arst_n)
		$rose(o_ref_pwr) |-> !o_conv_valid [*8];
	endproperty
	a_ref_wake: assert property (p_ref_wake) else $error("valid before reference settled");

	property p_core_wake;
		@(posedge i_clk) disable iff (!i_arst_n)
		($rose(o_core_pwr) && ref_ok) |-> !o_conv_valid [*8];
	endproperty
	a_core_wake: assert property (p_core_wake) else $error("valid before core started");

	property p_code;
		@(posedge i_clk) disable iff (!i_arst_n)
		(push && i_first_channel == 8'h80) |-> push_a == 8'h00;
	endproperty
	a_code: assert property (p_code) else $error("negative full scale not zero code");

	property p_ind_first;
		@(posedge i_clk) disable iff (!i_arst_n)
		s_first_upd |=> o_chan_ind && o_sample_bits == $past(tail_a);
	endproperty
	a_ind_first: assert property (p_ind_first) else $error("first channel update wrong");

	property p_ind_second;
		@(posedge i_clk) disable iff (!i_arst_n)
		s_second_upd |=> !o_chan_ind && o_sample_bits == $past(bhold_r);
	endproperty
	a_ind_second: assert property (p_ind_second) else $error("second channel update wrong");

	property p_hold;
		@(posedge i_clk) disable iff (!i_arst_n)
		!core_ok |=> $stable(o_sample_bits) && $stable(o_chan_ind);
	endproperty
	a_hold: assert property (p_hold) else $error("held word changed while halted");

	property p_enable_word;
		@(posedge i_clk) disable iff (!i_arst_n)
		($rose(o_sample_bits_oe) && !$past(word_upd)) |-> $stable(o_sample_bits);
	endproperty
	a_enable_word: assert property (p_enable_word) else $error("enable did not show last word");
endmodule // dao_top

// ### verif/dao_cap_model.sv
`timescale 1ns/1ps

// downstream capture: latches each driven word by the channel indicator
module dao_cap_model
	import dao_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// bus from the converter, receive only
	input wire dao_word_t i_sample_bits,
	input wire logic i_oe,
	input wire logic i_chan_ind,
	// captured words
	output dao_word_t o_cap_a,
	output dao_word_t o_cap_b
);
	// one receiver input per line keeps the load light, nothing is driven back
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_cap_a <= 8'h00;
			o_cap_b <= 8'h00;
		end else if (i_oe) begin
			if (i_chan_ind) begin
				o_cap_a <= i_sample_bits;
			end else begin
				o_cap_b <= i_sample_bits;
			end
		end
	end
endmodule // dao_cap_model

// ### verif/tb_top.sv
`timescale 1ns/1ps

module tb_top;
	import dao_pkg::*;
	localparam int SH = 8;
	// core wake must cover the eight halted cycles that a_core_wake demands
	localparam int SB = 8;
	logic i_clk = 0, i_arst_n = 0, i_smp_clk = 0;
	logic i_power_select_low = 0, i_power_select_high = 0;
	dao_word_t i_first_channel = 8'h00, i_second_channel = 8'h00;
	dao_word_t o_sample_bits, cap_a, cap_b, last;
	logic o_sample_bits_oe, o_chan_ind, o_chan_ind_oe, o_core_pwr, o_ref_pwr;
	logic o_clk_dist_pwr, o_conv_valid;
	int errors = 0, n_checks = 0, np = 0, n;
	dao_word_t ha[64], hb[64];
	dao_word_t vals[4] = '{8'h80, 8'h7f, 8'h00, 8'h5a};

	always #20 i_clk = ~i_clk;

	// short wake counts keep the run brief
	dao_top #(.SHDN_CYC(SH), .STBY_CYC(SB), .IDLE_CYC(1)) DUT (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_smp_clk(i_smp_clk),
		.i_power_select_low(i_power_select_low), .i_power_select_high(i_power_select_high),
		.i_first_channel(i_first_channel), .i_second_channel(i_second_channel),
		.o_sample_bits(o_sample_bits), .o_sample_bits_oe(o_sample_bits_oe),
		.o_chan_ind(o_chan_ind), .o_chan_ind_oe(o_chan_ind_oe), .o_core_pwr(o_core_pwr),
		.o_ref_pwr(o_ref_pwr), .o_clk_dist_pwr(o_clk_dist_pwr), .o_conv_valid(o_conv_valid));
	dao_cap_model u_cap (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_sample_bits(o_sample_bits),
		.i_oe(o_sample_bits_oe), .i_chan_ind(o_chan_ind), .o_cap_a(cap_a), .o_cap_b(cap_b));

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk8(input dao_word_t got, input dao_word_t exp, input string m);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp, input string m);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %b", $time, m, got);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge i_clk);
	endtask

	// bounded wait on conv_valid (sel 0) or output enable (sel 1)
	task automatic wait_hi(input int sel, output int k);
		k = 0;
		while ((sel ? o_sample_bits_oe : o_conv_valid) !== 1'b1) begin
			cyc(1);
			k++;
			if (k > 2000) begin
				errors++;
				$display("unexpected at %0t: wait ran out", $time);
				conclude();
			end
		end
	endtask

	// one sampling period; half periods are slow so the synchroniser keeps up
	task automatic push;
		ha[np] = vals[np % 4] ^ 8'h80;
		hb[np] = vals[(np + 1) % 4] ^ 8'h80;
		i_first_channel = vals[np % 4];
		i_second_channel = vals[(np + 1) % 4];
		i_smp_clk = 1;
		cyc(16);
		if (np >= 5) begin
			chk8(o_sample_bits, ha[np - 5], "first word");
			chk1(o_chan_ind, 1'b1, "indicator high");
			last = ha[np - 5];
		end
		i_smp_clk = 0;
		cyc(16);
		if (np >= 5) begin
			chk8(o_sample_bits, hb[np - 5], "second word");
			chk1(o_chan_ind, 1'b0, "indicator low");
			last = hb[np - 5];
		end
		np++;
	endtask

	// every select code and the sections it powers
	task automatic t_modes;
		for (int m = 0; m < 4; m++) begin
			{i_power_select_low, i_power_select_high} = m[1:0];
			cyc(6);
			chk1(o_core_pwr, m[1], "core power");
			chk1(o_ref_pwr, m != 0, "reference power");
			chk1(o_clk_dist_pwr, m != 0, "clock power");
			if (m < 3) chk1(o_sample_bits_oe | o_chan_ind_oe, 1'b0, "tri-state");
		end
		$display("test modes done");
	endtask

	task automatic t_shdn_wake;
		{i_power_select_low, i_power_select_high} = 2'b00;
		cyc(6);
		{i_power_select_low, i_power_select_high} = 2'b11;
		wait_hi(0, n);
		chk1(n >= SH && n <= SH + 8, 1'b1, "shutdown wake time");
		wait_hi(1, n);
		chk1(n <= 2 && o_chan_ind_oe === 1'b1, 1'b1, "drivers on");
		$display("test shutdown wake done");
	endtask

	task automatic t_stream;
		repeat (10) push();
		chk1(o_sample_bits_oe, 1'b1, "driven in normal");
		chk8(cap_b, last, "captured second word");
		chk8(cap_a, ha[np - 6], "captured first word");
		$display("test stream done");
	endtask

	// conversions keep running in idle; the newest word comes out first
	task automatic t_idle;
		{i_power_select_low, i_power_select_high} = 2'b10;
		cyc(6);
		chk1(o_sample_bits_oe, 1'b0, "idle tri-state");
		repeat (2) push();
		{i_power_select_low, i_power_select_high} = 2'b11;
		wait_hi(1, n);
		chk1(n <= 6, 1'b1, "idle wake time");
		chk8(o_sample_bits, last, "word on enable");
		$display("test idle done");
	endtask

	task automatic t_stby;
		{i_power_select_low, i_power_select_high} = 2'b01;
		cyc(6);
		chk1(o_conv_valid | o_core_pwr, 1'b0, "standby core off");
		{i_power_select_low, i_power_select_high} = 2'b11;
		wait_hi(0, n);
		chk1(n >= SB && n <= SB + 8, 1'b1, "standby wake time");
		$display("test standby wake done");
	endtask

	initial begin
		cyc(4);
		i_arst_n = 1;
		cyc(1);
		chk1(o_sample_bits_oe | o_core_pwr | o_ref_pwr, 1'b0, "reset state");
		t_modes();
		t_shdn_wake();
		t_stream();
		t_idle();
		t_stby();
		conclude();
	end
endmodule // tb_top
